/* scp_regs.vh */
// register map, reset values and timing constants of the serial control port
// assumes inclusion by bare name from the port module
`ifndef SCP_REGS_VH
`define SCP_REGS_VH

`define SCP_CLK_PERIOD_NS 20
`define SCP_STARTUP_NS 1000
`define SCP_FRAME_BITS 5'h10
`define SCP_ERR_WORD 16'h0E00

`define SCP_ADDR_STANDBY 7'h00
`define SCP_ADDR_MODE_A 7'h01
`define SCP_ADDR_MODE_B 7'h02
`define SCP_ADDR_MODE_SEL 7'h03
`define SCP_ADDR_POWER 7'h04
`define SCP_ADDR_GEN_CFG 7'h05
`define SCP_ADDR_DATA_CTRL 7'h06
`define SCP_ADDR_IFACE 7'h07
`define SCP_ADDR_AIN_PRECHG 7'h08
`define SCP_ADDR_REF_PRECHG 7'h09
`define SCP_ADDR_OFFSET 7'h0A
`define SCP_ADDR_GAIN 7'h0B
`define SCP_ADDR_PHASE 7'h0C
`define SCP_ADDR_REVISION 7'h0D
`define SCP_ADDR_STATUS 7'h0E
`define SCP_NUM_RW 7'h0D

`define SCP_RST_STANDBY 8'h00
`define SCP_RST_MODE 8'h0D
`define SCP_RST_MODE_SEL 8'h00
`define SCP_RST_POWER 8'h00
`define SCP_RST_GEN_CFG 8'h00
`define SCP_RST_DATA_CTRL 8'h00
`define SCP_RST_IFACE 8'h00
`define SCP_RST_AIN_PRECHG 8'hFF
`define SCP_RST_REF_PRECHG 8'h00
`define SCP_RST_CAL 8'h00

`define SCP_SYNC_BIT 0
`define SCP_RST_KEY1 8'h03
`define SCP_RST_KEY2 8'h02

`endif

/* scp_sync3.v */
// three-stage input synchroniser with agreement filter
// assumes inputs are asynchronous to clk_i; output is a clean level
`timescale 1ns/1ns
module scp_sync3 #(
   parameter WIDTH = 3,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   input wire clk_i,
   input wire reset_i,
   input wire [WIDTH-1:0] async_i,
   output reg [WIDTH-1:0] level_o
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   integer k;

   // stage1 feeds only stage2; a change counts once stages 2 and 3 agree
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         stage1 <= RESET_VAL;
         stage2 <= RESET_VAL;
         stage3 <= RESET_VAL;
         level_o <= RESET_VAL;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
         stage3 <= stage2;
         for (k = 0; k < WIDTH; k = k + 1) begin
            if (stage2[k] == stage3[k]) begin
               level_o[k] <= stage3[k];
            end
         end
      end
   end
endmodule

/* scp_ctrl_port.v */
// serial register control port: 16-bit mode 0 slave, off-frame replies
// assumes serial clock slow enough for 50 MHz oversampling (>=5 cycles/half)
// Operation
// - mode 0: clock idles low, drive on falling, sample on rising edge.
// - each frame carries exactly sixteen bits in each direction.
// - command bit 15 set means read, clear means write.
// - command bits 14 to 8 hold the seven-bit register address.
// - reply to a command is shifted out in the following frame.
// - write reply is eight zero bits followed by eight data bits.
// - illegal writes or reads answer with the error word 0x0E00.
// - port is independent of converter clocks and the data path.
// - serial accesses are ignored for a period after any reset.
// - reset default is low power mode, modulator rate master/32.
// - reset default interface: data clock master/8, header on, crc off.
// - both channel mode groups default to sinc5, decimation 1024.
// - channel group assignment defaults to zero, all in group A.
// - input precharge buffers on, reference precharge buffers off.
// - offset, gain and phase calibration default to zero.
// - conversion defaults to continuous rather than single-shot.
// - after port reset, the first command is answered with 0x0E00.
`timescale 1ns/1ns
`include "scp_regs.vh"
module scp_ctrl_port #(
   parameter LOCKOUT_NS = `SCP_STARTUP_NS,
   parameter CNT_W = 16,
   parameter [7:0] REVISION_ID = 8'h5A // arbitrary revision value
) (
   input wire core_clk_i,
   input wire reset_i,
   input wire ctrl_sel_i,
   input wire sclk_i,
   input wire cs_n_i,
   input wire mosi_i,
   output reg miso_o,
   output reg miso_oe_n_o,
   output reg sync_o,
   output reg busy_o,
   output wire [7:0] standby_o,
   output wire [7:0] mode_a_o,
   output wire [7:0] mode_b_o,
   output wire [7:0] mode_sel_o,
   output wire [7:0] power_mode_o,
   output wire [7:0] gen_cfg_o,
   output wire [7:0] data_ctrl_o,
   output wire [7:0] iface_cfg_o,
   output wire [7:0] ain_prechg_o,
   output wire [7:0] ref_prechg_o,
   output wire [7:0] offset_cal_o,
   output wire [7:0] gain_cal_o,
   output wire [7:0] phase_cal_o
);
   localparam integer LOCK_CYC =
      (LOCKOUT_NS + `SCP_CLK_PERIOD_NS - 1) / `SCP_CLK_PERIOD_NS;
   localparam [CNT_W-1:0] LOCK_CNT = LOCK_CYC[CNT_W-1:0];
   localparam [CNT_W-1:0] LOCK_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_FRAME = 3'b010;
   localparam [2:0] ST_DONE = 3'b100;

   function [7:0] reg_default;
      input [6:0] a;
      begin
         if (a == `SCP_ADDR_MODE_A || a == `SCP_ADDR_MODE_B)
            reg_default = `SCP_RST_MODE;
         else if (a == `SCP_ADDR_MODE_SEL)
            reg_default = `SCP_RST_MODE_SEL;
         else if (a == `SCP_ADDR_POWER)
            reg_default = `SCP_RST_POWER;
         else if (a == `SCP_ADDR_GEN_CFG)
            reg_default = `SCP_RST_GEN_CFG;
         else if (a == `SCP_ADDR_IFACE)
            reg_default = `SCP_RST_IFACE;
         else if (a == `SCP_ADDR_AIN_PRECHG)
            reg_default = `SCP_RST_AIN_PRECHG;
         else if (a == `SCP_ADDR_REF_PRECHG)
            reg_default = `SCP_RST_REF_PRECHG;
         else if (a == `SCP_ADDR_OFFSET || a == `SCP_ADDR_GAIN ||
                  a == `SCP_ADDR_PHASE)
            reg_default = `SCP_RST_CAL;
         else if (a == `SCP_ADDR_DATA_CTRL)
            reg_default = `SCP_RST_DATA_CTRL;
         else
            reg_default = `SCP_RST_STANDBY;
      end
   endfunction

   function addr_readable;
      input [6:0] a;
      begin
         addr_readable = (a <= `SCP_ADDR_STATUS);
      end
   endfunction

   function addr_writable;
      input [6:0] a;
      begin
         addr_writable = (a < `SCP_NUM_RW);
      end
   endfunction

   // one of the two port-reset keys written to the data control register
   function rst_key_hit;
      input [15:0] w;
      input [7:0] key;
      begin
         rst_key_hit = ~w[15] & (w[14:8] == `SCP_ADDR_DATA_CTRL) &
                       (w[7:0] == key);
      end
   endfunction

   wire [3:0] pin_level;
   wire sel_lvl;
   wire sclk_lvl;
   wire cs_n_lvl;
   wire mosi_lvl;

   // pins are sampled on the core clock only; no path to conversion data
   // control-select is a pin as well, so it rides the same filter
   scp_sync3 #(
      .WIDTH(4),
      .RESET_VAL(4'b0010)
   ) u_pin_sync (
      .clk_i(core_clk_i),
      .reset_i(reset_i),
      .async_i({ctrl_sel_i, sclk_i, cs_n_i, mosi_i}),
      .level_o(pin_level)
   );

   assign sel_lvl = pin_level[3];
   assign sclk_lvl = pin_level[2];
   assign cs_n_lvl = pin_level[1];
   assign mosi_lvl = pin_level[0];

   // one byte per writable address; the low address nibble indexes it
   reg [7:0] cfg [0:12];
   reg [2:0] state;
   reg sclk_q;
   reg cs_n_q;
   reg frame_ok;
   reg [4:0] bit_cnt;
   reg [15:0] rx_sh;
   reg [15:0] tx_sh;
   reg [15:0] resp;
   reg [CNT_W-1:0] lock_cnt;
   reg rst_armed;
   reg post_rst;
   integer i;

   wire sclk_rise = sclk_lvl & ~sclk_q;
   wire sclk_fall = ~sclk_lvl & sclk_q;
   wire cs_fall = ~cs_n_lvl & cs_n_q;
   wire cs_rise = cs_n_lvl & ~cs_n_q;

   wire cmd_rd = rx_sh[15];
   wire [6:0] cmd_addr = rx_sh[14:8];
   wire [7:0] cmd_data = rx_sh[7:0];
   wire cmd_legal = cmd_rd ? addr_readable(cmd_addr) :
                    addr_writable(cmd_addr);
   wire frame_full = (bit_cnt == `SCP_FRAME_BITS);
   wire is_ctrl_wr = ~cmd_rd & (cmd_addr == `SCP_ADDR_DATA_CTRL);
   wire key2_hit = rst_armed & rst_key_hit(rx_sh, `SCP_RST_KEY2);

   // read data is picked while the command still sits in the shifter
   reg [7:0] rd_byte;
   always @* begin
      rd_byte = 8'h00;
      if (cmd_addr == `SCP_ADDR_REVISION) begin
         rd_byte = REVISION_ID;
      end else if (cmd_addr == `SCP_ADDR_STATUS) begin
         rd_byte = {6'h00, rst_armed, busy_o};
      end else if (addr_writable(cmd_addr)) begin
         rd_byte = cfg[cmd_addr[3:0]];
      end
   end

   assign standby_o = cfg[0];
   assign mode_a_o = cfg[1];
   assign mode_b_o = cfg[2];
   assign mode_sel_o = cfg[3];
   assign power_mode_o = cfg[4];
   assign gen_cfg_o = cfg[5];
   assign data_ctrl_o = cfg[6];
   assign iface_cfg_o = cfg[7];
   assign ain_prechg_o = cfg[8];
   assign ref_prechg_o = cfg[9];
   assign offset_cal_o = cfg[10];
   assign gain_cal_o = cfg[11];
   assign phase_cal_o = cfg[12];

   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         for (i = 0; i < 13; i = i + 1) begin
            cfg[i] <= reg_default(i[6:0]);
         end
         state <= ST_IDLE;
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
         frame_ok <= 1'b0;
         bit_cnt <= 5'h00;
         rx_sh <= 16'h0000;
         tx_sh <= 16'h0000;
         resp <= 16'h0000;
         lock_cnt <= LOCK_CNT;
         busy_o <= 1'b1;
         rst_armed <= 1'b0;
         post_rst <= 1'b0;
         miso_o <= 1'b0;
         miso_oe_n_o <= 1'b1;
         sync_o <= 1'b0;
      end else begin
         sclk_q <= sclk_lvl;
         cs_n_q <= cs_n_lvl;
         sync_o <= 1'b0;
         // lockout window after any reset
         if (lock_cnt != {CNT_W{1'b0}}) begin
            lock_cnt <= lock_cnt - 1'b1;
         end
         busy_o <= (lock_cnt > LOCK_ONE);
         case (state)
            ST_IDLE: begin
               if (cs_fall) begin
                  state <= ST_FRAME;
                  bit_cnt <= 5'h00;
                  // frames opened during lockout or pin mode are ignored
                  frame_ok <= ~busy_o & sel_lvl;
                  // refused frames still drive the line, but only zeros
                  miso_oe_n_o <= 1'b0;
                  if (~busy_o & sel_lvl) begin
                     tx_sh <= resp;
                     miso_o <= resp[15];
                  end else begin
                     tx_sh <= 16'h0000;
                     miso_o <= 1'b0;
                  end
               end
            end
            ST_FRAME: begin
               if (sclk_rise) begin
                  rx_sh <= {rx_sh[14:0], mosi_lvl};
                  // saturate so an overlong frame never wraps back to 16
                  if (bit_cnt != 5'h1F) begin
                     bit_cnt <= bit_cnt + 5'h01;
                  end
               end
               if (sclk_fall) begin
                  tx_sh <= {tx_sh[14:0], 1'b0};
                  miso_o <= tx_sh[14];
               end
               if (cs_rise) begin
                  state <= ST_DONE;
                  miso_o <= 1'b0;
                  miso_oe_n_o <= 1'b1;
               end
            end
            ST_DONE: begin
               // decode only once the frame has closed, never mid-frame
               state <= ST_IDLE;
               // short or long frames leave the pending reply untouched
               if (frame_ok & frame_full) begin
                  rst_armed <= rst_key_hit(rx_sh, `SCP_RST_KEY1);
                  if (key2_hit) begin
                     for (i = 0; i < 13; i = i + 1) begin
                        cfg[i] <= reg_default(i[6:0]);
                     end
                     // a port reset restarts the lockout like a pin reset
                     lock_cnt <= LOCK_CNT;
                     busy_o <= 1'b1;
                     post_rst <= 1'b1;
                     resp <= {8'h00, cmd_data};
                  end else begin
                     if (~cmd_rd & cmd_legal) begin
                        cfg[cmd_addr[3:0]] <= cmd_data;
                     end
                     if (is_ctrl_wr & cmd_data[`SCP_SYNC_BIT]) begin
                        sync_o <= 1'b1;
                     end
                     // the command after a port reset still runs
                     if (post_rst) begin
                        post_rst <= 1'b0;
                        resp <= `SCP_ERR_WORD;
                     end else if (~cmd_legal) begin
                        resp <= `SCP_ERR_WORD;
                     end else if (cmd_rd) begin
                        resp <= {1'b0, cmd_addr, rd_byte};
                     end else begin
                        resp <= {8'h00, cmd_data};
                     end
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

/* scp_ctrl_monitor.sv */
// checker for the serial control port outputs
// assumes bind to scp_ctrl_port with a lockout of five core cycles
`timescale 1ns/1ns
module scp_ctrl_monitor (
   input wire core_clk_i,
   input wire reset_i,
   input wire sclk_i,
   input wire cs_n_i,
   input wire miso_o,
   input wire miso_oe_n_o,
   input wire sync_o,
   input wire busy_o,
   input wire [7:0] data_ctrl_o,
   input wire [7:0] gain_cal_o,
   input wire [7:0] offset_cal_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);
   AST_OE_IDLE:
      assert property (cs_n_i [*8] |-> miso_oe_n_o)
      else $error("output driven outside a frame");
   AST_OE_ZERO:
      assert property (miso_oe_n_o |-> !miso_o)
      else $error("data out not low while released");
   AST_MISO_HOLD:
      assert property (sclk_i && $past(sclk_i) && !cs_n_i |-> $stable(miso_o))
      else $error("data out moved while serial clock high");
   AST_BUSY_LEN:
      assert property ($fell(reset_i) |-> busy_o [*3] ##[1:3] !busy_o)
      else $error("lockout length wrong");
   AST_CFG_BUSY:
      assert property (busy_o && $past(busy_o) |-> $stable(offset_cal_o))
      else $error("config changed during lockout");
   AST_CFG_FRAME:
      assert property (!cs_n_i [*8] |-> $stable(gain_cal_o))
      else $error("config changed inside a frame");
   AST_SYNC_ONE:
      assert property (sync_o |=> !sync_o)
      else $error("sync pulse longer than one cycle");
   AST_SYNC_CAUSE:
      assert property ($rose(sync_o) |-> ##[0:1] data_ctrl_o[0])
      else $error("sync without control bit");
endmodule
bind scp_ctrl_port scp_ctrl_monitor mon_u (
   .core_clk_i(core_clk_i), .reset_i(reset_i), .sclk_i(sclk_i),
   .cs_n_i(cs_n_i), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o),
   .sync_o(sync_o), .busy_o(busy_o), .data_ctrl_o(data_ctrl_o),
   .gain_cal_o(gain_cal_o), .offset_cal_o(offset_cal_o));

/* scp_host_model.sv */
// host side serial master: mode 0, 16-bit frames, slow clock
// assumes the bench clock is core_clk_i; everything moves on its fall
`timescale 1ns/1ns
module scp_host_model (
   input wire core_clk_i,
   input wire miso_i,
   output reg sclk_o,
   output reg cs_n_o,
   output reg mosi_o
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b1;
   end
   task wt(input integer n);
      repeat (n) @(negedge core_clk_i);
   endtask
   // sends one command and collects the reply to the previous one
   task xfer(input [15:0] cmd, output [15:0] rsp);
      integer i;
      begin
         wt(1);
         cs_n_o = 1'b0;
         for (i = 15; i >= 0; i = i - 1) begin
            mosi_o = cmd[i];
            wt(10);
            sclk_o = 1'b1;
            rsp[i] = miso_i;
            wt(10);
            sclk_o = 1'b0;
         end
         wt(10);
         cs_n_o = 1'b1;
         // released line shows the inverse so a stale bit is not trusted
         mosi_o = ~mosi_o;
         wt(15);
      end
   endtask
endmodule

/* scp_ctrl_port_tb_top.sv */
// self-checking bench for the serial control port
// assumes the host model as far side and a shortened lockout
`timescale 1ns/1ns
module scp_ctrl_port_tb_top;
   reg core_clk_i = 1'b0;
   reg reset_i = 1'b1;
   reg ctrl_sel_i = 1'b1;
   wire sclk_i, cs_n_i, mosi_i, miso_o, miso_oe_n_o, sync_o, busy_o;
   wire [7:0] cfg [0:12];
   integer num_errors = 0;
   integer tests_run = 0;
   integer cycles = 0;
   integer syncs = 0;
   reg [15:0] r;
   always #10 core_clk_i = ~core_clk_i;
   scp_ctrl_port #(.LOCKOUT_NS(100), .REVISION_ID(8'hC3)) dut_u (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i), .ctrl_sel_i(ctrl_sel_i), .sclk_i(sclk_i),
      .cs_n_i(cs_n_i), .mosi_i(mosi_i), .miso_o(miso_o),
      .miso_oe_n_o(miso_oe_n_o), .sync_o(sync_o), .busy_o(busy_o),
      .standby_o(cfg[0]), .mode_a_o(cfg[1]), .mode_b_o(cfg[2]),
      .mode_sel_o(cfg[3]), .power_mode_o(cfg[4]), .gen_cfg_o(cfg[5]),
      .data_ctrl_o(cfg[6]), .iface_cfg_o(cfg[7]), .ain_prechg_o(cfg[8]),
      .ref_prechg_o(cfg[9]), .offset_cal_o(cfg[10]),
      .gain_cal_o(cfg[11]), .phase_cal_o(cfg[12]));
   scp_host_model host_u (.core_clk_i(core_clk_i), .miso_i(miso_o),
      .sclk_o(sclk_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i));
   always @(posedge core_clk_i) begin
      if (sync_o === 1'b1)
         syncs = syncs + 1;
   end
   task chk(input [15:0] got, input [15:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            $display("BAD %0t got %h exp %h", $time, got, exp);
            num_errors = num_errors + 1;
         end
      end
   endtask
   task give_verdict;
      begin
         $display("errors %0d checks %0d", num_errors, tests_run);
         if (num_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task t_defaults;
      integer i;
      reg [7:0] e;
      begin
         for (i = 0; i < 13; i = i + 1) begin
            e = (i == 1 || i == 2) ? 8'h0D : (i == 8) ? 8'hFF : 8'h00;
            chk({8'h00, cfg[i]}, {8'h00, e});
         end
      end
   endtask
   task t_access;
      begin
         host_u.xfer(16'h0A5C, r);
         host_u.xfer(16'h8A00, r);
         chk(r, 16'h005C);
         chk({8'h00, cfg[10]}, 16'h005C);
         host_u.xfer(16'h8B00, r);
         chk(r, 16'h0A5C);
         host_u.xfer(16'h0D11, r);
         chk(r, 16'h0B00);
         host_u.xfer(16'hFF00, r);
         chk(r, 16'h0E00);
         host_u.xfer(16'h1033, r);
         chk(r, 16'h0E00);
         host_u.xfer(16'h8A00, r);
         chk(r, 16'h0E00);
         ctrl_sel_i = 1'b0;
         host_u.xfer(16'h0B77, r);
         chk(r, 16'h0000);
         ctrl_sel_i = 1'b1;
         chk({8'h00, cfg[11]}, 16'h0000);
         host_u.xfer(16'h0601, r);
         chk(r, 16'h0A5C);
         chk(syncs, 16'h0001);
         host_u.xfer(16'h8D00, r);
         chk(r, 16'h0001);
      end
   endtask
   task t_soft_reset;
      begin
         host_u.xfer(16'h0603, r);
         chk(r, 16'h0DC3);
         host_u.xfer(16'h0602, r);
         chk(r, 16'h0003);
         chk({cfg[6], cfg[10]}, 16'h0000);
         host_u.xfer(16'h8600, r);
         chk(r, 16'h0002);
         host_u.xfer(16'h8000, r);
         chk(r, 16'h0E00);
      end
   endtask
   // pin reset in mid-run: defaults back, pending reply cleared
   task t_hard_reset;
      begin
         host_u.xfer(16'h0A77, r);
         chk(r, 16'h0000);
         chk({8'h00, cfg[10]}, 16'h0077);
         reset_i = 1'b1;
         host_u.wt(2);
         reset_i = 1'b0;
         host_u.wt(10);
         chk({8'h00, cfg[10]}, 16'h0000);
         chk({15'h0000, busy_o}, 16'h0000);
         host_u.xfer(16'h8A00, r);
         chk(r, 16'h0000);
         host_u.xfer(16'h8000, r);
         chk(r, 16'h0A00);
      end
   endtask
   always @(posedge core_clk_i) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         num_errors = num_errors + 1;
         give_verdict;
      end
   end
   initial begin
      repeat (12) @(negedge core_clk_i);
      reset_i = 1'b0;
      host_u.wt(10);
      chk({15'h0000, busy_o}, 16'h0000);
      t_defaults;
      t_access;
      t_soft_reset;
      t_hard_reset;
      give_verdict;
   end
endmodule
